// [hdl/rsq_map.svh]
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

// Processing clock and power-system frequency
`define RSQ_SYS_CLK_HZ   20000000
`define RSQ_LINE_HZ      60
// Clocks per power-system cycle, rounded down
`define RSQ_CYCLE_CLKS   (`RSQ_SYS_CLK_HZ / `RSQ_LINE_HZ)

// Field widths
`define RSQ_TMR_W        24
`define RSQ_SHOT_W       3
`define RSQ_TICK_W       20
`define RSQ_NUM_OI       4
`define RSQ_NUM_SHOT     5

// Reset values and limits
`define RSQ_SHOT_RST     3'h0
`define RSQ_SHOT_MAX     3'h4
`define RSQ_TMR_RST      24'h000000
`define RSQ_TICK_RST     20'h00000

`endif

// [hdl/rsq_pkg.sv]
`include "rsq_map.svh"

package rsq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    RSQ_ST_RESET   = 3'b001,
    RSQ_ST_CYCLE   = 3'b010,
    RSQ_ST_LOCKOUT = 3'b100
  } rsq_state_t;

  // Sequencer state
  typedef struct packed {
    rsq_state_t                  st;
    logic [`RSQ_SHOT_W-1:0]      shot;
    logic                        ri_prev;
    logic                        seq_prev;
    logic                        closed_prev;
    logic                        armed;
    logic                        seq_pend;
    logic                        rs_use_lo;
    logic [`RSQ_TMR_W-1:0]       oi_cnt;
    logic [`RSQ_TMR_W-1:0]       rs_cnt;
    logic                        flag_rs;
    logic                        flag_cy;
    logic                        flag_lo;
    logic                        oia;
    logic                        rsa;
    logic [`RSQ_NUM_SHOT-1:0]    shot_flags;
    logic                        close_req;
  } rsq_top_t;

  // Cycle tick generator state
  typedef struct packed {
    logic [`RSQ_TICK_W-1:0] cnt;
    logic                   tick;
  } rsq_tick_t;

endpackage

// [hdl/rsq_tick.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rsq_map.svh"

module rsq_tick
  import rsq_pkg::*;
#(
  parameter int CYCLE_CLKS = `RSQ_CYCLE_CLKS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      cycle_tick
);

  rsq_tick_t q_ff;
  rsq_tick_t nxt_q;

  // Free-running divider, one pulse per power-system cycle
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.tick = 1'b0;
    if (q_ff.cnt == `RSQ_TICK_W'(CYCLE_CLKS - 1)) begin
      nxt_q.cnt  = `RSQ_TICK_RST;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.cnt = q_ff.cnt + `RSQ_TICK_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cycle_tick = q_ff.tick;

endmodule

`default_nettype wire

// [hdl/rsq_top.sv]
//Function
//RULE1: Reset only after reset timer qualifies closure
//RULE2: Cycle-state closures timed on cycle reset time
//RULE3: Sequence coordination uses cycle reset time
//RULE4: Lockout-state closures timed on lockout reset time
//RULE5: Power-up or setting change loads lockout time
//RULE6: Both reset times independent, any order
//RULE7: Block-reset condition halts reset timing
//RULE8: Open-interval-active high only while interval times
//RULE9: Interval times in cycle, initiated, not stalled
//RULE10: Reset-timer-active high only while reset timing
//RULE11: Shot zero first interval, increments on expiry
//RULE12: Reclose shot count never exceeds last shot
//RULE13: Shot count cleared on return to reset
//RULE14: One of five shot flags matches count
//RULE15: Sequence coordination increments shot past last
//RULE16: Programmable condition inputs for all functions
//RULE17: Initiate on rising edge with supervision true
//RULE18: Rising edge without supervision goes lockout
//RULE19: Last shot counts nonzero intervals before zero
//RULE20: Defeated reclosing forces all flags low
//RULE21: Times counted in cycles, conditions per tick
`timescale 1ns/1ns
`default_nettype none
`include "rsq_map.svh"

module rsq_top
  import rsq_pkg::*;
#(
  parameter int CYCLE_CLKS = `RSQ_CYCLE_CLKS
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   reclose_enable,
  input  wire logic                   settings_change,
  input  wire logic [`RSQ_TMR_W-1:0]  open_interval_first,
  input  wire logic [`RSQ_TMR_W-1:0]  open_interval_second,
  input  wire logic [`RSQ_TMR_W-1:0]  open_interval_third,
  input  wire logic [`RSQ_TMR_W-1:0]  open_interval_fourth,
  input  wire logic [`RSQ_TMR_W-1:0]  cycle_reset_time,
  input  wire logic [`RSQ_TMR_W-1:0]  lockout_reset_time,
  input  wire logic                   breaker_closed_status,
  input  wire logic                   reclose_initiate_cond,
  input  wire logic                   initiate_supervision_cond,
  input  wire logic                   drive_lockout_cond,
  input  wire logic                   drive_final_shot_cond,
  input  wire logic                   skip_shot_cond,
  input  wire logic                   stall_interval_cond,
  input  wire logic                   reset_block_cond,
  input  wire logic                   sequence_coord_cond,
  input  wire logic                   reclose_supervision_cond,
  output logic                        state_reset_flag,
  output logic                        state_cycle_flag,
  output logic                        state_lockout_flag,
  output logic                        open_interval_active,
  output logic                        reset_timer_active,
  output logic [`RSQ_NUM_SHOT-1:0]    shot_flags,
  output logic                        reclose_request
);

  rsq_top_t                q_ff;
  rsq_top_t                nxt_q;
  logic                    cycle_tick;
  logic [`RSQ_TMR_W-1:0]   oi_set [`RSQ_NUM_OI];
  logic [`RSQ_NUM_OI-1:0]  oi_run;
  logic [`RSQ_SHOT_W-1:0]  last_shot;
  logic                    defeated;

  // One tick per power-system cycle
  rsq_tick #(
    .CYCLE_CLKS (CYCLE_CLKS)
  ) u_tick (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .cycle_tick (cycle_tick)
  ); // RULE21

  assign oi_set[0] = open_interval_first;
  assign oi_set[1] = open_interval_second;
  assign oi_set[2] = open_interval_third;
  assign oi_set[3] = open_interval_fourth;

  // Run of nonzero intervals starting at the first
  genvar gi;
  generate
    for (gi = 0; gi < `RSQ_NUM_OI; gi++) begin : g_oi
      if (gi == 0) begin : g_first
        assign oi_run[gi] = (oi_set[gi] != `RSQ_TMR_RST);
      end else begin : g_rest
        assign oi_run[gi] = oi_run[gi-1] & (oi_set[gi] != `RSQ_TMR_RST);
      end
    end
  endgenerate

  // Last shot is the length of that run
  // A zero setting ends the run, so any later
  // nonzero interval is simply never used
  always_comb begin
    last_shot = `RSQ_SHOT_RST;
    for (int i = 0; i < `RSQ_NUM_OI; i++) begin
      last_shot = last_shot + `RSQ_SHOT_W'(oi_run[i]); // RULE19
    end
  end

  // Defeated when disabled or first interval zero
  // Defeat only masks the flags; the internal state
  // still parks in lockout underneath
  assign defeated = ~reclose_enable | ~oi_run[0];

  // Enter lockout, dropping any interval in progress
  // Reset timing restarts on the lockout duration so a
  // manual close is qualified with that time
  function automatic rsq_top_t go_lockout(input rsq_top_t s);
    rsq_top_t r;
    r           = s;
    r.st        = RSQ_ST_LOCKOUT;
    r.armed     = 1'b0;
    r.oi_cnt    = `RSQ_TMR_RST;
    r.rs_cnt    = `RSQ_TMR_RST;
    r.rs_use_lo = 1'b1;
    return r;
  endfunction

  // Sequencer next state, evaluated once per tick
  always_comb begin
    logic                    ri_rise;
    logic                    seq_rise;
    logic                    opened;
    logic                    timing;
    logic                    rs_run;
    logic [`RSQ_TMR_W-1:0]   oi_time;
    logic [`RSQ_TMR_W-1:0]   rs_dur;
    ri_rise   = 1'b0;
    seq_rise  = 1'b0;
    opened    = 1'b0;
    timing    = 1'b0;
    rs_run    = 1'b0;
    oi_time   = `RSQ_TMR_RST;
    rs_dur    = `RSQ_TMR_RST;
    nxt_q           = q_ff;
    nxt_q.close_req = 1'b0;
    if (cycle_tick) begin
      // Edge detection on sampled conditions
      // Edges are tick to tick, so a pulse shorter
      // than one tick period can be missed
      ri_rise  = reclose_initiate_cond & ~q_ff.ri_prev; // RULE17
      seq_rise = sequence_coord_cond & ~q_ff.seq_prev;
      opened   = q_ff.closed_prev & ~breaker_closed_status;
      nxt_q.ri_prev     = reclose_initiate_cond; // RULE21
      nxt_q.seq_prev    = sequence_coord_cond;
      nxt_q.closed_prev = breaker_closed_status;

      // Interval for the current shot, none at shot four
      // Shot four arises when last shot is four, or from coordination steps
      if (q_ff.shot < `RSQ_SHOT_W'(`RSQ_NUM_OI)) begin
        oi_time = oi_set[q_ff.shot[1:0]]; // RULE11
      end

      // Open interval timing
      // Stall freezes the count rather than clearing it,
      // so timing resumes where it left off
      timing = (q_ff.st == RSQ_ST_CYCLE) & q_ff.armed & ~stall_interval_cond; // RULE9
      if (timing) begin
        if (q_ff.oi_cnt + `RSQ_TMR_W'(1) >= oi_time) begin
          nxt_q.oi_cnt    = `RSQ_TMR_RST;
          nxt_q.armed     = 1'b0;
          nxt_q.close_req = reclose_supervision_cond; // RULE16
          if (q_ff.shot < last_shot) begin
            nxt_q.shot = q_ff.shot + `RSQ_SHOT_W'(1); // RULE11 RULE12
          end
        end else begin
          nxt_q.oi_cnt = q_ff.oi_cnt + `RSQ_TMR_W'(1);
        end
      end

      // Reset timer qualifies a closed breaker
      // In reset the timer still runs after a coordination
      // step or a setting change, to bring the shot home
      rs_run = breaker_closed_status & ~reset_block_cond
               & ((q_ff.st != RSQ_ST_RESET) | q_ff.seq_pend
                  | q_ff.rs_use_lo); // RULE1 RULE7
      if (q_ff.st == RSQ_ST_LOCKOUT || (q_ff.rs_use_lo && !q_ff.seq_pend)) begin
        rs_dur = lockout_reset_time; // RULE4 RULE5 RULE6
      end else begin
        rs_dur = cycle_reset_time; // RULE2 RULE3
      end
      if (rs_run) begin
        if (q_ff.rs_cnt + `RSQ_TMR_W'(1) >= rs_dur) begin
          nxt_q.st        = RSQ_ST_RESET; // RULE1
          nxt_q.shot      = `RSQ_SHOT_RST; // RULE13
          nxt_q.seq_pend  = 1'b0;
          nxt_q.rs_use_lo = 1'b0;
          nxt_q.rs_cnt    = `RSQ_TMR_RST;
          nxt_q.armed     = 1'b0;
        end else begin
          nxt_q.rs_cnt = q_ff.rs_cnt + `RSQ_TMR_W'(1);
        end
      end else begin
        nxt_q.rs_cnt = `RSQ_TMR_RST;
      end

      // Sequence coordination advances the shot
      // Only taken in reset; the count may pass last shot
      if (seq_rise && q_ff.st == RSQ_ST_RESET) begin
        if (q_ff.shot < `RSQ_SHOT_MAX) begin
          nxt_q.shot = q_ff.shot + `RSQ_SHOT_W'(1); // RULE15
        end
        nxt_q.seq_pend = 1'b1;
        nxt_q.rs_cnt   = `RSQ_TMR_RST; // RULE3
      end

      // Reclose initiation
      if (ri_rise && q_ff.st != RSQ_ST_LOCKOUT) begin
        if (!initiate_supervision_cond || q_ff.shot >= last_shot) begin
          nxt_q = go_lockout(nxt_q); // RULE18
        end else begin
          nxt_q.st        = RSQ_ST_CYCLE;
          nxt_q.armed     = 1'b1; // RULE17
          nxt_q.oi_cnt    = `RSQ_TMR_RST;
          nxt_q.rs_cnt    = `RSQ_TMR_RST;
          nxt_q.rs_use_lo = 1'b0;
          nxt_q.seq_pend  = 1'b0;
          if (skip_shot_cond) begin
            nxt_q.shot = q_ff.shot + `RSQ_SHOT_W'(1);
          end
        end
      end else if (opened && q_ff.st == RSQ_ST_RESET) begin
        // Breaker opened with no initiation
        nxt_q = go_lockout(nxt_q);
      end

      // Drive to last shot
      // Never lowers a shot already at or past last shot
      if (drive_final_shot_cond && nxt_q.shot < last_shot) begin
        nxt_q.shot = last_shot;
      end

      // No shot left while an interval is pending and breaker open
      // Skip or drive-to-last can land here with breaker open
      if (nxt_q.st == RSQ_ST_CYCLE && nxt_q.armed && nxt_q.shot >= last_shot
          && !breaker_closed_status) begin
        nxt_q = go_lockout(nxt_q);
      end

      // Drive to lockout
      if (drive_lockout_cond) begin
        nxt_q = go_lockout(nxt_q);
      end

      // Setting change: last shot and lockout reset time
      // Applied late in the tick so it wins over any
      // shot movement decided above
      if (settings_change) begin
        nxt_q.shot      = last_shot;
        nxt_q.rs_use_lo = 1'b1; // RULE5
        nxt_q.rs_cnt    = `RSQ_TMR_RST;
      end

      // Defeated sequencer parks in lockout
      if (defeated) begin
        nxt_q = go_lockout(nxt_q);
        nxt_q.close_req = 1'b0;
      end

      // Registered status flags
      // Taken from the next state so every output
      // comes straight from a flip-flop
      nxt_q.flag_rs = (nxt_q.st == RSQ_ST_RESET) & ~defeated; // RULE20
      nxt_q.flag_cy = (nxt_q.st == RSQ_ST_CYCLE) & ~defeated;
      nxt_q.flag_lo = (nxt_q.st == RSQ_ST_LOCKOUT) & ~defeated;
      nxt_q.oia     = (nxt_q.st == RSQ_ST_CYCLE) & nxt_q.armed
                      & ~stall_interval_cond; // RULE8
      nxt_q.rsa     = breaker_closed_status & ~reset_block_cond & ~defeated
                      & ((nxt_q.st != RSQ_ST_RESET) | nxt_q.seq_pend
                         | nxt_q.rs_use_lo); // RULE10
      for (int i = 0; i < `RSQ_NUM_SHOT; i++) begin
        nxt_q.shot_flags[i] = ~defeated
                              & (nxt_q.shot == `RSQ_SHOT_W'(i)); // RULE14 RULE20
      end
    end
  end

  // Power-up lands in lockout with lockout reset time armed
  // A closed breaker then reaches reset after the lockout
  // reset time, as after a manual close
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff           <= '0;
      q_ff.st        <= RSQ_ST_LOCKOUT;
      q_ff.rs_use_lo <= 1'b1; // RULE5
      q_ff.shot      <= `RSQ_SHOT_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign state_reset_flag     = q_ff.flag_rs;
  assign state_cycle_flag     = q_ff.flag_cy;
  assign state_lockout_flag   = q_ff.flag_lo;
  assign open_interval_active = q_ff.oia;
  assign reset_timer_active   = q_ff.rsa;
  assign shot_flags           = q_ff.shot_flags;
  assign reclose_request      = q_ff.close_req;

endmodule

`default_nettype wire

// [tb/rsq_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rsq_map.svh"

module rsq_monitor
  import rsq_pkg::*;
#(
  parameter int CYCLE_CLKS = 4
) (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic                     reclose_enable,
  input wire logic                     breaker_closed_status,
  input wire logic                     stall_interval_cond,
  input wire logic                     reset_block_cond,
  input wire logic                     reclose_supervision_cond,
  input wire logic                     state_reset_flag,
  input wire logic                     state_cycle_flag,
  input wire logic                     state_lockout_flag,
  input wire logic                     open_interval_active,
  input wire logic                     reset_timer_active,
  input wire logic [`RSQ_NUM_SHOT-1:0] shot_flags,
  input wire logic                     reclose_request
);
  // All checks on the processing clock, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_shot_onehot: assert property (
    $onehot0(shot_flags)) else $error("shot flags not one-hot");
  chk_defeat_clear: assert property (
    !reclose_enable [*6] |-> {state_reset_flag, state_cycle_flag, state_lockout_flag,
    shot_flags} == 8'h00) else $error("flags not cleared when defeated");
  chk_interval_cycle: assert property (
    open_interval_active |-> state_cycle_flag) else $error("interval outside cycle");
  chk_stall_holds: assert property (
    stall_interval_cond [*6] |-> !open_interval_active) else $error("interval ran stalled");
  chk_block_holds: assert property (
    reset_block_cond [*6] |-> !reset_timer_active) else $error("reset ran while blocked");
  chk_reset_entry: assert property (
    $rose(state_reset_flag) |-> shot_flags == 5'h01 && $past(breaker_closed_status))
    else $error("bad reset entry");
  chk_req_pulse: assert property (
    reclose_request |-> $past(reclose_supervision_cond) ##1 !reclose_request)
    else $error("bad reclose request");
  chk_req_shot: assert property (
    reclose_request |-> shot_flags == {$past(shot_flags[3:0]), 1'b0})
    else $error("shot not stepped at expiry");
  chk_tick_hold: assert property (
    $changed(shot_flags) |=> $stable(shot_flags) [*3]) else $error("shot moved off tick");
endmodule
`default_nettype wire

// [tb/rsq_breaker_model.sv]
`timescale 1ns/1ns
`default_nettype none

module rsq_breaker_model #(
  parameter int OPEN_DLY  = 6,
  parameter int CLOSE_DLY = 10
) (
  input  wire logic clk,
  input  wire logic trip_cmd,
  input  wire logic close_cmd,
  input  wire logic slow,
  input  wire logic reclose_request,
  output logic      breaker_closed,
  output logic      trip_out
);
  int open_cnt  = 0;
  int close_cnt = 0;

  initial breaker_closed = 1'b1;
  initial trip_out = 1'b0;
  // Trip output, mechanism delays for opening and closing
  always @(posedge clk) begin
    trip_out <= trip_cmd;
    if (open_cnt > 0) begin
      open_cnt <= open_cnt - 1;
      if (open_cnt == 1) breaker_closed <= 1'b0;
    end else if (trip_cmd && breaker_closed) begin
      open_cnt <= OPEN_DLY;
    end
    if (close_cnt > 0) begin
      close_cnt <= close_cnt - 1;
      if (close_cnt == 1) breaker_closed <= 1'b1;
    end else if ((reclose_request || close_cmd) && !breaker_closed) begin
      close_cnt <= slow ? 2 * CLOSE_DLY : CLOSE_DLY; // Slow mode doubles delay
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rsq_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module testbench;
  import rsq_pkg::*;
  localparam int CC = 4;
  localparam logic [2:0] RS = 3'b100;
  localparam logic [2:0] CY = 3'b010;
  localparam logic [2:0] LO = 3'b001;
  logic clk = 0, sys_rst = 1, en = 1, chg = 0, trip = 0, mclose = 0, slow = 0, probe = 0;
  logic ris = 1, dtl = 0, dls = 0, skp = 0, stl = 0, brs = 0, seq = 0, cls = 1;
  logic [`RSQ_TMR_W-1:0]   oi [4];
  logic [`RSQ_NUM_SHOT-1:0] shf;
  logic [9:0]              notes [$];
  logic [9:0]              want;
  wire logic               bk, ri, rs_f, cy_f, lo_f, oia, rsa, req;
  wire logic [9:0]         obs = {rs_f, cy_f, lo_f, oia, rsa, shf};
  int                      err_count = 0;
  int                      checked = 0;
  int                      cyc = 0;
  int unsigned             rnd = 36314;

  always #25 clk = ~clk;
  // Breaker and trip logic on the far side
  rsq_breaker_model bkr (.clk(clk), .trip_cmd(trip), .close_cmd(mclose), .slow(slow),
    .reclose_request(req), .breaker_closed(bk), .trip_out(ri));
  // Sequencer with a short cycle tick
  rsq_top #(.CYCLE_CLKS(CC)) dut (.clk(clk), .sys_rst(sys_rst), .reclose_enable(en),
    .settings_change(chg), .open_interval_first(oi[0]), .open_interval_second(oi[1]),
    .open_interval_third(oi[2]), .open_interval_fourth(oi[3]),
    .cycle_reset_time(24'h00000c), .lockout_reset_time(24'h000003),
    .breaker_closed_status(bk), .reclose_initiate_cond(ri), .initiate_supervision_cond(ris),
    .drive_lockout_cond(dtl), .drive_final_shot_cond(dls), .skip_shot_cond(skp),
    .stall_interval_cond(stl), .reset_block_cond(brs), .sequence_coord_cond(seq),
    .reclose_supervision_cond(cls), .state_reset_flag(rs_f), .state_cycle_flag(cy_f),
    .state_lockout_flag(lo_f), .open_interval_active(oia), .reset_timer_active(rsa),
    .shot_flags(shf), .reclose_request(req));

  function int unsigned xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic logic [9:0] ex(logic [2:0] s, logic o, logic r, int n);
    return {s, o, r, 5'h01 << n};
  endfunction
  task tk(input int n);
    repeat (n * CC) @(negedge clk);
  endtask
  // Queue an expected snapshot for the watcher
  task note(input logic [9:0] e);
    notes.push_back(e);
    probe <= 1'b1;
    @(negedge clk);
    probe <= 1'b0;
  endtask
  task wait_req;
    int k;
    k = 0;
    while (req !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k >= 400) begin
      err_count++;
      $display("[FAIL] %0t no reclose request", $time);
    end
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watcher compares outputs with the oldest note
  always @(negedge clk) begin
    if (probe === 1'b1) begin
      want = notes.pop_front();
      `CHK(obs, want)
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish;
    end
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 2; i++) oi[i] = 24'(1 + xs() % 3);
    oi[2] = 24'h000000;
    oi[3] = 24'(1 + xs() % 5);
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    tk(6);
    note(ex(RS, 0, 0, 0));
    stl = 1;
    trip = 1;
    tk(3);
    note(ex(CY, 0, 0, 0));
    trip = 0;
    stl = 0;
    wait_req;
    note(ex(CY, 0, 0, 1));
    tk(6);
    note(ex(CY, 0, 1, 1));
    brs = 1;
    tk(3);
    note(ex(CY, 0, 0, 1));
    brs = 0;
    slow = 1;
    trip = 1;
    tk(1);
    trip = 0;
    wait_req;
    note(ex(CY, 0, 0, 2));
    tk(8);
    trip = 1;
    tk(1);
    trip = 0;
    tk(3);
    note(ex(LO, 0, 0, 2));
    slow = 0;
    mclose = 1;
    tk(1);
    mclose = 0;
    tk(3);
    note(ex(LO, 0, 1, 2));
    tk(4);
    note(ex(RS, 0, 0, 0));
    ris = 0;
    trip = 1;
    tk(1);
    trip = 0;
    tk(3);
    note(ex(LO, 0, 0, 0));
    ris = 1;
    mclose = 1;
    tk(1);
    mclose = 0;
    tk(8);
    en = 0;
    tk(3);
    note(10'h000);
    en = 1;
    tk(8);
    note(ex(RS, 0, 0, 0));
    seq = 1;
    tk(2);
    note(ex(RS, 0, 1, 1));
    seq = 0;
    tk(4);
    note(ex(RS, 0, 1, 1));
    tk(10);
    note(ex(RS, 0, 0, 0));
    chg = 1;
    tk(1);
    chg = 0;
    tk(1);
    note(ex(RS, 0, 1, 2));
    tk(4);
    note(ex(RS, 0, 0, 0));
    dtl = 1;
    dls = 1;
    tk(1);
    dtl = 0;
    dls = 0;
    tk(1);
    note(ex(LO, 0, 1, 2));
    tk(4);
    note(ex(RS, 0, 0, 0));
    skp = 1;
    stl = 1;
    trip = 1;
    tk(1);
    trip = 0;
    tk(1);
    skp = 0;
    stl = 0;
    wait_req;
    note(ex(CY, 0, 0, 2));
    tk(16);
    note(ex(RS, 0, 0, 0));
    tally_and_finish;
  end
endmodule

bind rsq_top rsq_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) mon (.clk(clk), .sys_rst(sys_rst),
  .reclose_enable(reclose_enable), .breaker_closed_status(breaker_closed_status),
  .stall_interval_cond(stall_interval_cond), .reset_block_cond(reset_block_cond),
  .reclose_supervision_cond(reclose_supervision_cond), .state_reset_flag(state_reset_flag),
  .state_cycle_flag(state_cycle_flag), .state_lockout_flag(state_lockout_flag),
  .open_interval_active(open_interval_active), .reset_timer_active(reset_timer_active),
  .shot_flags(shot_flags), .reclose_request(reclose_request));
`default_nettype wire
